/* design/irq_cmd_regs.sv */
// command and status registers of the vectored interrupt unit
// assumes sources and the vectoring core sit on the same clock as the bus
`timescale 1ns/10ps
module irq_cmd_regs
  import irq_cmd_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // interrupt sources, level high
  input  wire logic [31:0] source_level,
  // vectoring core side
  input  wire logic        core_current_valid,
  input  wire logic [31:0] core_current_vector,
  input  wire logic        core_fast_valid,
  input  wire logic [31:0] core_fast_vector,
  output logic             vector_taken,
  output logic             end_of_service,
  output logic [31:0]      source_enable_readback,
  output logic [31:0]      pending,
  // processor request lines, active low
  output logic             fast_request_out_n,
  output logic             normal_request_out_n,
  // block interrupt
  output logic             intr_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0]      mask;
  logic [31:0]      spurious_vector;
  logic [1:0]       debug_control;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic             aw_held;
  logic             w_held;
  logic [11:0]      wr_addr;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;

  // ----------------------------------------
  // write channel decode
  // ----------------------------------------
  wire        aw_hs      = awvalid & awready;
  wire        w_hs       = wvalid & wready;
  wire        do_write   = aw_held & w_held & ~bvalid;
  wire [31:0] byte_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wr_bits    = wr_data & byte_mask;
  wire        wr_enable  = do_write & (wr_addr == OFF_ENABLE_CMD);
  wire        wr_disable = do_write & (wr_addr == OFF_DISABLE_CMD);
  wire        wr_pclear  = do_write & (wr_addr == OFF_PCLEAR_CMD);
  wire        wr_pset    = do_write & (wr_addr == OFF_PSET_CMD);
  wire        wr_eos     = do_write & (wr_addr == OFF_EOS_CMD);
  wire        wr_spur    = do_write & (wr_addr == OFF_SPURIOUS);
  wire        wr_debug   = do_write & (wr_addr == OFF_DEBUG);
  wire        wr_estat   = do_write & (wr_addr == OFF_EVT_STATUS);
  wire        wr_emask   = do_write & (wr_addr == OFF_EVT_MASK);
  // protection mode lets a debugger read vectors with no acknowledge;
  // the vector is then acknowledged by a write to the normal vector read
  wire        wr_nvec    = do_write & (wr_addr == OFF_NORMAL_VEC);
  wire        wr_mapped  = wr_enable | wr_disable | wr_pclear | wr_pset | wr_eos
                         | wr_spur | wr_debug | wr_estat | wr_emask | wr_nvec;

  assign awready = ~aw_held & ~bvalid;
  assign wready  = ~w_held & ~bvalid;

  // ----------------------------------------
  // read channel decode
  // ----------------------------------------
  wire        ar_hs        = arvalid & arready;
  wire        protection_mode_enable_mode    = debug_control[PROTECTION_MODE_ENABLE_BIT];
  wire        global_mask  = debug_control[GMASK_BIT];
  wire        rd_nvec      = ar_hs & (araddr == OFF_NORMAL_VEC);
  wire        rd_fvec      = ar_hs & (araddr == OFF_FAST_VEC);
  wire [31:0] line_status;
  // (R14) spurious when idle
  wire [31:0] normal_vec_value = core_current_valid ? core_current_vector : spurious_vector;
  // (R11) spurious fast vector
  wire [31:0] fast_vec_value   = core_fast_valid ? core_fast_vector : spurious_vector;
  logic [31:0] rd_value;
  logic        rd_hit;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    unique case (araddr)
      OFF_NORMAL_VEC:  rd_value = normal_vec_value;
      OFF_FAST_VEC:    rd_value = fast_vec_value;
      OFF_PENDING:     rd_value = pending;
      // (R1) enabled reads 1
      OFF_EN_READBACK: rd_value = mask;
      OFF_LINE_STATUS: rd_value = line_status;
      OFF_SPURIOUS:    rd_value = spurious_vector;
      OFF_DEBUG:       rd_value = {30'h0000_0000, debug_control};
      OFF_EVT_STATUS:  rd_value = {29'h0000_0000, evt_status};
      OFF_EVT_MASK:    rd_value = {29'h0000_0000, evt_mask};
      default:         rd_hit   = 1'b0;
    endcase
  end

  assign arready = ~rvalid;

  // ----------------------------------------
  // request lines
  // ----------------------------------------
  wire [31:0] active       = pending & mask;
  // (R2) bit 0 fast, 1 up normal
  wire        fast_active   = active[FAST_SOURCE_BIT];
  wire        normal_active = |active[31:SYSTEM_SOURCE_BIT];
  // (R3) fast line status
  assign line_status[FAST_LINE_BIT]   = ~fast_request_out_n;
  // (R4) normal line status
  assign line_status[NORMAL_LINE_BIT] = ~normal_request_out_n;
  assign line_status[31:2]            = 30'h0000_0000;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  // (R5) (R6) enable then disable
  wire [31:0] next_mask    = wr_enable ? (mask | wr_bits)
                           : wr_disable ? (mask & ~wr_bits) : mask;
  // (R7) (R8) source level wins over clear
  wire [31:0] next_pending = (pending & ~(wr_pclear ? wr_bits : 32'h0000_0000))
                           | (wr_pset ? wr_bits : 32'h0000_0000) | source_level;
  wire [EVT_W-1:0] evt_set;
  assign evt_set[EVT_SPUR_NORMAL] = rd_nvec & ~core_current_valid;
  assign evt_set[EVT_SPUR_FAST]   = rd_fvec & ~core_fast_valid;
  assign evt_set[EVT_END_SERVICE] = wr_eos;
  // set wins over write-one-to-clear
  wire [EVT_W-1:0] next_evt = (evt_status & ~(wr_estat ? wr_bits[EVT_W-1:0] : RST_EVT))
                            | evt_set;
  // interrupt follows a new mask in the same cycle the mask lands
  wire [EVT_W-1:0] next_emask = wr_emask ? wr_data[EVT_W-1:0] : evt_mask;

  // ----------------------------------------
  // bus registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (w_hs)
      begin
        w_held  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_value;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ----------------------------------------
  // block state
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask            <= RST_MASK;
      pending         <= RST_PENDING;
      spurious_vector <= RST_SPURIOUS;
      debug_control   <= RST_DEBUG;
      evt_status      <= RST_EVT;
      evt_mask        <= RST_EVT;
    end
    else
    begin
      mask    <= next_mask;
      pending <= next_pending;
      evt_status <= next_evt;
      if (wr_spur)
        spurious_vector <= wr_data;
      // (R12) protection bit
      if (wr_debug)
        debug_control <= wr_data[1:0];
      if (wr_emask)
        evt_mask <= wr_data[EVT_W-1:0];
    end
  end

  // ----------------------------------------
  // outputs to core and processor
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fast_request_out_n   <= 1'b1;
      normal_request_out_n <= 1'b1;
      vector_taken         <= 1'b0;
      end_of_service       <= 1'b0;
      intr_out             <= 1'b0;
    end
    else
    begin
      // (R13) global mask forces idle
      fast_request_out_n   <= ~(fast_active & ~global_mask);
      normal_request_out_n <= ~(normal_active & ~global_mask);
      vector_taken         <= protection_mode_enable_mode ? wr_nvec : rd_nvec;
      // (R9) any data ends service
      end_of_service       <= wr_eos;
      intr_out             <= |(next_evt & next_emask);
    end
  end

  assign source_enable_readback = mask;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence write_eos_s;
    wr_eos;
  endsequence

  sequence line_high_s;
    end_of_service;
  endsequence

  eos_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R9)
    write_eos_s |=> line_high_s ##1 !end_of_service)
    else $error("end of service pulse wrong");

  enable_sets_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R5)
    wr_enable |=> ((mask & $past(wr_bits)) == $past(wr_bits)))
    else $error("enable command did not set mask");

  disable_clears_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R6)
    wr_disable |=> ((mask & $past(wr_bits)) == 32'h0000_0000))
    else $error("disable command did not clear mask");

  mask_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R1)
    !wr_enable && !wr_disable |=> $stable(source_enable_readback))
    else $error("mask changed without command");

  pset_forces_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R8)
    wr_pset |=> ((pending & $past(wr_bits)) == $past(wr_bits)))
    else $error("set command did not force pending");

  pclear_works_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R7)
    wr_pclear && !wr_pset |=>
      ((pending & $past(wr_bits) & ~$past(source_level)) == 32'h0000_0000))
    else $error("clear command did not clear pending");

  gmask_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R13)
    global_mask |=> fast_request_out_n && normal_request_out_n)
    else $error("request line active under global mask");

  fast_line_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R3)
    fast_active && !global_mask |=> !fast_request_out_n && line_status[FAST_LINE_BIT])
    else $error("fast line or its status wrong");

  normal_line_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R4)
    normal_active && !global_mask |=> !normal_request_out_n && line_status[NORMAL_LINE_BIT])
    else $error("normal line or its status wrong");

  spur_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R14)
    rd_nvec && !core_current_valid |=> rvalid && rdata == $past(spurious_vector))
    else $error("idle vector read not spurious value");

  protection_mode_enable_reset_a: assert property (@(posedge aclk) // (R12)
    !aresetn |=> !protection_mode_enable_mode)
    else $error("protection bit not cleared by reset");

  protection_mode_enable_noside_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R12)
    protection_mode_enable_mode && rd_nvec && !wr_nvec |=> !vector_taken)
    else $error("vector read acknowledged in protection mode");

  spur_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R11)
    wr_spur |=> spurious_vector == $past(wr_data))
    else $error("spurious vector not stored");

  fast_src_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R2)
    active == 32'h0000_0001 && !global_mask |=> normal_request_out_n)
    else $error("fast source drove normal line");

  fast_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R3)
    !fast_active || global_mask |=> fast_request_out_n && !line_status[FAST_LINE_BIT])
    else $error("fast line active with nothing to request");

  normal_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R4)
    !normal_active || global_mask |=> normal_request_out_n && !line_status[NORMAL_LINE_BIT])
    else $error("normal line active with nothing to request");

  readback_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R1)
    ar_hs && araddr == OFF_EN_READBACK |=> rdata == $past(mask))
    else $error("mask readback wrong");

  pend_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R7)
    !wr_pclear |=> (($past(pending) & ~pending) == 32'h0000_0000))
    else $error("pending bit dropped without clear");

  eos_only_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R9)
    !wr_eos |=> !end_of_service)
    else $error("end of service without a write");

  fast_spur_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R11)
    rd_fvec && !core_fast_valid |=> rvalid && rdata == $past(spurious_vector))
    else $error("idle fast vector read not spurious value");

  fast_vec_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R11)
    rd_fvec && core_fast_valid |=> rdata == $past(core_fast_vector))
    else $error("fast vector read wrong");

  spur_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R11)
    !wr_spur |=> $stable(spurious_vector))
    else $error("spurious vector changed without write");

  protection_mode_enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R12)
    wr_debug |=> protection_mode_enable_mode == $past(wr_data[PROTECTION_MODE_ENABLE_BIT]))
    else $error("protection bit not stored");

  taken_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R12)
    rd_nvec && !protection_mode_enable_mode |=> vector_taken)
    else $error("vector read not acknowledged");

endmodule : irq_cmd_regs

/* design/irq_cmd_pkg.sv */
// constants for the interrupt command and status register block
// assumes one 125 MHz clock and an axi4-lite master on the register side
// Operation
// (R1) mask readback bit reads 1 for an enabled source, 0 for disabled
// (R2) bit 0 is the fast source, bit 1 system, bits 2-31 peripherals
// (R3) core status bit 0 reads 1 while the fast request line is active
// (R4) core status bit 1 reads 1 while the normal request line is active
// (R5) enable command sets mask bits written as 1, zeros leave them
// (R6) disable command clears mask bits written as 1, zeros leave them
// (R7) clear command clears pending bits written as 1, zeros no change; here a bit whose source level is high stays set
// (R8) set command forces pending bits written as 1, zeros no change
// (R9) any write to end-of-service marks the current interrupt done
// (R10) handler software writes end-of-service when its treatment ends
// (R11) spurious vector holds a 32-bit value returned on spurious reads
// (R12) debug bit 0 enables protection mode, resets to 0
// (R13) debug bit 1 high holds both request outputs inactive
// (R14) normal vector read returns spurious vector when nothing is current
package irq_cmd_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_NORMAL_VEC   = 12'h100;
  localparam logic [11:0] OFF_FAST_VEC     = 12'h104;
  localparam logic [11:0] OFF_PENDING      = 12'h10c;
  localparam logic [11:0] OFF_EN_READBACK  = 12'h110;
  localparam logic [11:0] OFF_LINE_STATUS  = 12'h114;
  localparam logic [11:0] OFF_ENABLE_CMD   = 12'h120;
  localparam logic [11:0] OFF_DISABLE_CMD  = 12'h124;
  localparam logic [11:0] OFF_PCLEAR_CMD   = 12'h128;
  localparam logic [11:0] OFF_PSET_CMD     = 12'h12c;
  localparam logic [11:0] OFF_EOS_CMD      = 12'h130;
  localparam logic [11:0] OFF_SPURIOUS     = 12'h134;
  localparam logic [11:0] OFF_DEBUG        = 12'h138;
  localparam logic [11:0] OFF_EVT_STATUS   = 12'h140;
  localparam logic [11:0] OFF_EVT_MASK     = 12'h144;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FAST_SOURCE_BIT     = 0;
  localparam int SYSTEM_SOURCE_BIT   = 1;
  localparam int FAST_LINE_BIT       = 0;
  localparam int NORMAL_LINE_BIT     = 1;
  localparam int PROTECTION_MODE_ENABLE_BIT            = 0;
  localparam int GMASK_BIT           = 1;
  localparam int EVT_SPUR_NORMAL     = 0;
  localparam int EVT_SPUR_FAST       = 1;
  localparam int EVT_END_SERVICE     = 2;
  localparam int EVT_W               = 3;

  // ----------------------------------------
  // reset values and bus answers
  // ----------------------------------------
  localparam logic [31:0] RST_MASK      = 32'h0000_0000;
  localparam logic [31:0] RST_PENDING   = 32'h0000_0000;
  localparam logic [31:0] RST_SPURIOUS  = 32'h0000_0000;
  localparam logic [1:0]  RST_DEBUG     = 2'h0;
  localparam logic [2:0]  RST_EVT       = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : irq_cmd_pkg

/* dv/cpu_line_model.sv */
// processor side model: samples both active-low request lines
// assumes the lines change only just after the rising clock edge
`timescale 1ns/10ps
module cpu_line_model
(
  // clock
  input  wire logic aclk,
  // request lines, active low
  input  wire logic fast_request_out_n,
  input  wire logic normal_request_out_n,
  // line state as the core saw it
  output logic      fast_seen,
  output logic      normal_seen
);
  // ----------------------------------------
  // line sampling
  // ----------------------------------------
  // one edge late, like a core input stage
  always_ff @(posedge aclk)
  begin
    fast_seen   <= !fast_request_out_n;
    normal_seen <= !normal_request_out_n;
  end
endmodule : cpu_line_model

/* dv/tb_interrupt_command_status_regs.sv */
// bench for the interrupt command and status registers
// assumes an axi4-lite master here and a line model on the request side
`timescale 1ns/10ps
module tb_interrupt_command_status_regs
  import irq_cmd_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, taken, eos;
  logic        fast_n, norm_n, intr, f_seen, n_seen, cur_ok, fst_ok, gm;
  logic [11:0] awaddr, araddr;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  strb;
  logic [31:0] wdata, src, cur_vec, fst_vec, rdata, pend, en_rb;
  logic [31:0] seed, mask_m, pend_m, spur_m, d, q;
  int          bad_count = 0, checks_done = 0, eos_cnt = 0, tkn_cnt = 0, k;

  // ----------------------------------------
  // clock, pulse counters, instances
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // counted mid-cycle, clear of the edge that launches each pulse
  always @(negedge aclk)
  begin
    eos_cnt += eos;
    tkn_cnt += taken;
  end
  irq_cmd_regs i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .source_level(src), .core_current_valid(cur_ok),
    .core_current_vector(cur_vec), .core_fast_valid(fst_ok), .core_fast_vector(fst_vec),
    .vector_taken(taken), .end_of_service(eos), .source_enable_readback(en_rb),
    .pending(pend), .fast_request_out_n(fast_n), .normal_request_out_n(norm_n),
    .intr_out(intr));
  cpu_line_model i_cpu (.aclk(aclk), .fast_request_out_n(fast_n),
    .normal_request_out_n(norm_n), .fast_seen(f_seen), .normal_seen(n_seen));

  // ----------------------------------------
  // helpers and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] lines_exp();
    if (gm)
      return 32'h0;
    return {30'h0, |(pend_m[31:1] & mask_m[31:1]), pend_m[0] & mask_m[0]};
  endfunction : lines_exp
  task automatic close_out();
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chk_r
  // handshakes judged at the falling edge, acted on after the rising one
  task automatic wr(input logic [11:0] a, input logic [31:0] dv);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dv;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
    if (k == 40)
    begin
      bad_count++;
      close_out();
    end
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic ha, hr;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      q  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) break;
    end
    rready <= 1'b0;
    if (k == 40)
    begin
      bad_count++;
      close_out();
    end
  endtask : rd

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, cur_ok, fst_ok, gm} = '0;
    {awaddr, araddr, wdata, src, cur_vec, fst_vec} = '0;
    {mask_m, pend_m, spur_m} = '0;
    strb = 4'hf;
    seed = 32'h9102;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_DEBUG);
    chk(q, 32'h0);
    rd(OFF_EN_READBACK);
    chk(q, mask_m);
    // random command words, model kept alongside
    repeat (6)
    begin
      d = xs();
      wr(OFF_ENABLE_CMD, d);
      mask_m |= d;
      d = xs();
      wr(OFF_DISABLE_CMD, d);
      mask_m &= ~d;
      rd(OFF_EN_READBACK);
      chk(q, mask_m);
      d = xs();
      wr(OFF_PSET_CMD, d);
      pend_m |= d;
      d = xs();
      wr(OFF_PCLEAR_CMD, d);
      pend_m &= ~d;
      rd(OFF_PENDING);
      chk(q, pend_m);
      rd(OFF_LINE_STATUS);
      chk(q, lines_exp());
      chk({30'h0, n_seen, f_seen}, lines_exp());
    end
    // only the strobed byte of a command word acts
    strb <= 4'h1;
    wr(OFF_DISABLE_CMD, 32'hffff_fffc);
    strb <= 4'hf;
    mask_m &= ~32'h0000_00fc;
    rd(OFF_EN_READBACK);
    chk(q, mask_m);
    // a held source level outlasts a clear
    src <= 32'h20;
    wr(OFF_PCLEAR_CMD, 32'h20);
    pend_m |= 32'h20;
    chk(pend, pend_m);
    src <= 32'h0;
    wr(OFF_PCLEAR_CMD, 32'h20);
    pend_m &= ~32'h20;
    chk(pend, pend_m);
    // global mask holds both lines inactive
    wr(OFF_ENABLE_CMD, 32'h3);
    wr(OFF_PSET_CMD, 32'h3);
    {mask_m, pend_m} = {mask_m | 32'h3, pend_m | 32'h3};
    wr(OFF_DEBUG, 32'h2);
    gm = 1'b1;
    rd(OFF_LINE_STATUS);
    chk(q, lines_exp());
    chk({30'h0, norm_n, fast_n}, 32'h3);
    wr(OFF_DEBUG, 32'h0);
    gm = 1'b0;
    rd(OFF_LINE_STATUS);
    chk(q, 32'h3);
    // spurious and current vectors
    spur_m = xs();
    wr(OFF_SPURIOUS, spur_m);
    rd(OFF_SPURIOUS);
    chk(q, spur_m);
    rd(OFF_FAST_VEC);
    chk(q, spur_m);
    fst_ok <= 1'b1;
    fst_vec <= xs();
    rd(OFF_FAST_VEC);
    chk(q, fst_vec);
    fst_ok <= 1'b0;
    d = tkn_cnt;
    rd(OFF_NORMAL_VEC);
    chk(q, spur_m);
    cur_ok <= 1'b1;
    cur_vec <= xs();
    rd(OFF_NORMAL_VEC);
    chk(q, cur_vec);
    chk(tkn_cnt, d + 2);
    // protection mode moves the acknowledge to a write
    wr(OFF_DEBUG, 32'h1);
    rd(OFF_DEBUG);
    chk(q, 32'h1);
    rd(OFF_NORMAL_VEC);
    chk(tkn_cnt, d + 2);
    wr(OFF_NORMAL_VEC, 32'h0);
    chk(tkn_cnt, d + 3);
    wr(OFF_DEBUG, 32'h0);
    cur_ok <= 1'b0;
    // handler signals end of treatment, any data
    d = eos_cnt;
    wr(OFF_EOS_CMD, 32'h0);
    wr(OFF_EOS_CMD, xs());
    chk(eos_cnt, d + 2);
    // event interrupt: raise, mask, clear
    wr(OFF_EVT_STATUS, 32'h7);
    wr(OFF_EVT_MASK, 32'h1);
    rd(OFF_NORMAL_VEC);
    rd(OFF_EVT_STATUS);
    chk(q, 32'h1);
    chk(intr, 1'b1);
    wr(OFF_EVT_MASK, 32'h0);
    rd(OFF_EVT_STATUS);
    chk(intr, 1'b0);
    wr(OFF_EVT_STATUS, 32'h1);
    rd(OFF_EVT_STATUS);
    chk(q, 32'h0);
    // idle fast read and end of service raise their own events
    rd(OFF_FAST_VEC);
    wr(OFF_EOS_CMD, 32'h0);
    rd(OFF_EVT_STATUS);
    chk(q, 32'h6);
    wr(OFF_EVT_STATUS, 32'h6);
    rd(OFF_EVT_STATUS);
    chk(q, 32'h0);
    // unmapped and read-only places refuse
    rd(12'h118);
    chk_r(r, RESP_SLVERR);
    wr(OFF_EN_READBACK, 32'hffff_ffff);
    chk_r(r, RESP_SLVERR);
    chk(en_rb, mask_m);
    close_out();
  end
endmodule : tb_interrupt_command_status_regs
